/* File: acp_ctrl.sv */
// Converter digital control: registers, stop modes, conversion sequencer
`include "acp_params.svh"
module acp_ctrl #(
	parameter int CONV_CYC = 23
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Register port
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// Power mode and trigger
	input wire logic [1:0] PMODE,
	input wire logic HW_TRIG,
	// Analog result
	input wire logic [9:0] CONV_DATA,
	// Outputs
	output logic IRQ,
	output logic [4:0] CHANNEL,
	output logic [7:0] GPIO_DIS_ONE,
	output logic [7:0] GPIO_DIS_TWO
);
	acp_pkg::acp_bus_s bus;
	acp_pkg::acp_pmode_e pmode;
	acp_pkg::acp_state_e state_q;
	logic [7:0] cfg_q, sc2_q, cvh_q, cvl_q;
	logic [4:0] ch_q;
	logic ien_q, cont_q, completion_flag_q, blk_q;
	logic [9:0] res_q;
	logic [7:0] cnt_q;
	logic [1:0] pmode_q;
	logic st12, stop_in, stop3_in, abort, start, done, cmp_ok, xfer, mode10;
	logic wcfg, wsc1, wsc2, wcv;
	logic [10:0] diff;

	assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
	assign pmode = acp_pkg::acp_pmode_e'(PMODE);
	assign st12 = (pmode == acp_pkg::ACP_STOP12);
	assign stop_in = (pmode != acp_pkg::ACP_RUN) && (pmode_q == 2'b00);
	assign stop3_in = stop_in && (pmode == acp_pkg::ACP_STOP3);
	assign mode10 = cfg_q[`ACP_CFG_MODE_HI:`ACP_CFG_MODE_LO] == `ACP_MODE_10;
	assign wcfg = bus.wr && bus.addr == `ACP_OFF_CFG;
	assign wsc1 = bus.wr && bus.addr == `ACP_OFF_SC1;
	assign wsc2 = bus.wr && bus.addr == `ACP_OFF_SC2;
	assign wcv = bus.wr && (bus.addr == `ACP_OFF_CVH ||
		bus.addr == `ACP_OFF_CVL);

	// ----------------------------------------------------------------
	// Abort and start decisions
	// ----------------------------------------------------------------
	// Clock select sampled at the stop entry edge itself
	assign abort = st12 || wcfg || wsc2 || wcv ||
		(stop3_in && cfg_q[1:0] != `ACP_CLK_ASYNC); // [R1] [R4] [R21]
	// Software trigger in run or stop3; hardware trigger only in run or with async clock
	assign start = (wsc1 && bus.wdata[4:0] != `ACP_CH_OFF &&
		!sc2_q[`ACP_SC2_TRG]) ||
		(HW_TRIG && sc2_q[`ACP_SC2_TRG] && ch_q != `ACP_CH_OFF &&
		(pmode == acp_pkg::ACP_RUN ||
		cfg_q[1:0] == `ACP_CLK_ASYNC)); // [R3] [R5]
	assign done = state_q == acp_pkg::ACP_CONV &&
		cnt_q == 8'(CONV_CYC - 1);
	assign diff = {1'b0, CONV_DATA} - {1'b0, cvh_q[1:0], cvl_q};
	assign cmp_ok = !sc2_q[`ACP_SC2_CFE] ||
		(sc2_q[`ACP_SC2_CGT] ? !diff[10] : diff[10]);
	assign xfer = done && cmp_ok && !blk_q; // [R8]

	// ----------------------------------------------------------------
	// Stop mode tracking
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pmode_q <= 2'b00;
		end else begin
			pmode_q <= PMODE;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_q <= acp_pkg::ACP_IDLE;
			cnt_q <= 8'h00;
		end else begin
			case (state_q)
				acp_pkg::ACP_IDLE: begin
					cnt_q <= 8'h00;
					if (start && !abort) begin
						state_q <= acp_pkg::ACP_CONV;
					end
				end
				acp_pkg::ACP_CONV: begin
					cnt_q <= cnt_q + 8'h01;
					if (abort) begin
						state_q <= acp_pkg::ACP_IDLE; // [R1]
					end else if (wsc1) begin
						cnt_q <= 8'h00;
						if (!start) begin
							state_q <= acp_pkg::ACP_IDLE;
						end
					end else if (done) begin
						cnt_q <= 8'h00;
						// Blocked results always restart unless compare gates a single conversion
						if (!(cont_q || (blk_q && cmp_ok))) begin
							state_q <= acp_pkg::ACP_IDLE; // [R17]
						end
					end
				end
				default: begin
					state_q <= acp_pkg::ACP_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cfg_q <= `ACP_RST_ZERO;
		end else if (st12) begin
			cfg_q <= `ACP_RST_ZERO; // [R9]
		end else if (wcfg) begin
			cfg_q <= bus.wdata; // [R12] [R13]
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			sc2_q <= `ACP_RST_ZERO;
		end else if (st12) begin
			sc2_q <= `ACP_RST_ZERO; // [R9]
		end else if (wsc2) begin
			sc2_q <= {1'b0, bus.wdata[6:4], 4'h0}; // [R14] [R15]
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cvh_q <= `ACP_RST_ZERO;
			cvl_q <= `ACP_RST_ZERO;
		end else if (st12) begin
			cvh_q <= `ACP_RST_ZERO; // [R9]
			cvl_q <= `ACP_RST_ZERO;
		end else if (bus.wr && bus.addr == `ACP_OFF_CVH) begin
			cvh_q <= bus.wdata; // [R19]
		end else if (bus.wr && bus.addr == `ACP_OFF_CVL) begin
			cvl_q <= bus.wdata; // [R19]
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ch_q <= `ACP_CH_OFF;
			ien_q <= 1'b0;
			cont_q <= 1'b0;
		end else if (st12) begin
			ch_q <= `ACP_CH_OFF; // [R9]
			ien_q <= 1'b0;
			cont_q <= 1'b0;
		end else if (wsc1) begin
			ch_q <= bus.wdata[4:0]; // [R16]
			ien_q <= bus.wdata[`ACP_SC1_IEN];
			cont_q <= bus.wdata[`ACP_SC1_CONT]; // [R17]
		end
	end

	// ----------------------------------------------------------------
	// Result, completion flag and read blocking
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			res_q <= 10'h000;
		end else if (st12) begin
			res_q <= 10'h000; // [R9]
		end else if (xfer) begin
			res_q <= sc2_q[`ACP_SC2_CFE] ? diff[9:0] : CONV_DATA; // [R2]
		end
	end

	// Set wins over the clear by a control write
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			completion_flag_q <= 1'b0;
		end else if (st12) begin
			completion_flag_q <= 1'b0;
		end else if (xfer) begin
			completion_flag_q <= 1'b1; // [R6]
		end else if (wsc1 || wsc2 || wcfg || wcv ||
				(bus.rd && bus.addr == `ACP_OFF_RL)) begin
			completion_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			blk_q <= 1'b0;
		end else if (st12 || !mode10) begin
			blk_q <= 1'b0;
		end else if (bus.rd && bus.addr == `ACP_OFF_RH) begin
			blk_q <= 1'b1; // [R8] [R18]
		end else if (bus.rd && bus.addr == `ACP_OFF_RL) begin
			blk_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Pin control
	// ----------------------------------------------------------------
	acp_pinmux #(.WIDTH(8)) u_pc1 (
		.clk(CLK),
		.rst_b(RST_B),
		.clr(st12),
		.we(bus.wr && bus.addr == `ACP_OFF_PC1),
		.wdata(bus.wdata),
		.ctl_q(GPIO_DIS_ONE)
	);

	acp_pinmux #(.WIDTH(8)) u_pc2 (
		.clk(CLK),
		.rst_b(RST_B),
		.clr(st12),
		.we(bus.wr && bus.addr == `ACP_OFF_PC2),
		.wdata(bus.wdata),
		.ctl_q(GPIO_DIS_TWO)
	);

	// ----------------------------------------------------------------
	// Read port, interrupt and channel outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			RDATA <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				`ACP_OFF_SC1: RDATA <= {completion_flag_q, ien_q, cont_q, ch_q};
				`ACP_OFF_SC2: RDATA <= {state_q == acp_pkg::ACP_CONV,
					sc2_q[6:4], 4'h0}; // [R14] [R15]
				`ACP_OFF_RH: RDATA <= {6'h00, res_q[9:8]};
				`ACP_OFF_RL: RDATA <= res_q[7:0];
				`ACP_OFF_CVH: RDATA <= cvh_q;
				`ACP_OFF_CVL: RDATA <= cvl_q;
				`ACP_OFF_CFG: RDATA <= cfg_q;
				`ACP_OFF_PC1: RDATA <= GPIO_DIS_ONE;
				`ACP_OFF_PC2: RDATA <= GPIO_DIS_TWO;
				default: RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			IRQ <= 1'b0;
			CHANNEL <= `ACP_CH_OFF;
		end else begin
			IRQ <= completion_flag_q && ien_q; // [R6]
			CHANNEL <= ch_q;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_stop_abort;
		@(posedge CLK) disable iff (!RST_B)
		(stop3_in && cfg_q[1:0] != `ACP_CLK_ASYNC) |=>
			state_q == acp_pkg::ACP_IDLE;
	endproperty
	a_stop_abort: assert property (p_stop_abort) else $error("no abort"); // [R1]

	property p_res_keep;
		@(posedge CLK) disable iff (!RST_B)
		(pmode == acp_pkg::ACP_STOP3 && !xfer) |=> $stable(res_q);
	endproperty
	a_res_keep: assert property (p_res_keep) else $error("result moved"); // [R2]

	property p_idle_stay;
		@(posedge CLK) disable iff (!RST_B)
		(state_q == acp_pkg::ACP_IDLE && !start) |=>
			state_q == acp_pkg::ACP_IDLE;
	endproperty
	a_idle_stay: assert property (p_idle_stay) else $error("self start"); // [R3]

	property p_async_go;
		@(posedge CLK) disable iff (!RST_B)
		(stop3_in && cfg_q[1:0] == `ACP_CLK_ASYNC &&
			state_q == acp_pkg::ACP_CONV && !done) |=>
			state_q == acp_pkg::ACP_CONV;
	endproperty
	a_async_go: assert property (p_async_go) else $error("stopped"); // [R4]

	property p_irq;
		@(posedge CLK) disable iff (!RST_B)
		(xfer && ien_q && !st12) |=> ##1 IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing"); // [R6]

	property p_block;
		@(posedge CLK) disable iff (!RST_B)
		(done && blk_q && !completion_flag_q) |=> !completion_flag_q;
	endproperty
	a_block: assert property (p_block) else $error("blocked set"); // [R8]

	property p_st12;
		@(posedge CLK) disable iff (!RST_B)
		st12 |=> (cfg_q == 8'h00 && ch_q == `ACP_CH_OFF && !ien_q);
	endproperty
	a_st12: assert property (p_st12) else $error("not reset"); // [R9]

	property p_sc2_zero;
		@(posedge CLK) disable iff (!RST_B)
		(bus.rd && bus.addr == `ACP_OFF_SC2) |=> RDATA[3:0] == 4'h0;
	endproperty
	a_sc2_zero: assert property (p_sc2_zero) else $error("bits set"); // [R15]

	property p_single;
		@(posedge CLK) disable iff (!RST_B)
		(done && !cont_q && !blk_q && !wsc1) |=>
			state_q == acp_pkg::ACP_IDLE;
	endproperty
	a_single: assert property (p_single) else $error("not single"); // [R17]

	c_done: cover property (@(posedge CLK) disable iff (!RST_B) xfer);
	c_stop3_conv: cover property (@(posedge CLK) disable iff (!RST_B)
		pmode == acp_pkg::ACP_STOP3 && xfer);
	c_blocked: cover property (@(posedge CLK) disable iff (!RST_B)
		done && blk_q);
	c_cmp_miss: cover property (@(posedge CLK) disable iff (!RST_B)
		done && !cmp_ok);

	// Failed compare leaves the result registers alone
	property p_cmp_gate;
		@(posedge CLK) disable iff (!RST_B)
		(done && !cmp_ok && !st12) |=> $stable(res_q);
	endproperty
	a_cmp_gate: assert property (p_cmp_gate) else $error("gated result"); // [R19]
endmodule

/* File: acp_params.svh */
// Register map, field positions, reset values and timing constants
// Summary of operation
// [R1] Stop entry without async clock selected aborts conversion and returns to idle.
// [R2] Stop3 entry or exit leaves the result high and low bytes unchanged.
// [R3] After stop3 exit without async clock, stay idle until a new trigger.
// [R4] With async clock selected, conversions continue through stop3 to completion.
// [R5] In stop3 with async clock, hardware trigger or continuous mode starts conversions.
// [R6] Completion in stop3 sets the flag and, if enabled, raises the wake interrupt.
// [R7] Software clears the result read blocking before staying in stop3 converting.
// [R8] High byte read but low byte unread in 10-bit mode blocks new results.
// [R9] Stop1 or stop2 disables the converter and resets every register.
// [R10] After stop1 or stop2 software re-enables and fully reconfigures the converter.
// [R11] Software writes configuration, then trigger/compare, then channel/complete control.
// [R12] Configuration: low power 7, divider 6:5, long sample 4, mode 3:2, clock 1:0.
// [R13] Divider 00 is divide by one, mode 10 is 10-bit, clock 00 is bus.
// [R14] Trigger/compare control: active 7, trigger select 6, compare 5, direction 4.
// [R15] Trigger/compare bits 3:2 read zero; software writes zero to bits 1:0.
// [R16] Channel/complete control: flag 7, irq enable 6, channel 4:0.
// [R17] Bit 5 selects continuous conversion; zero means one conversion per trigger.
// [R18] Software reads the result high byte before the low byte.
// [R19] Compare value high and low registers hold the compare threshold.
// [R20] A set pin-control bit disables general-purpose I/O for that pin.
// [R21] Abort or continue follows the clock select in effect at stop entry.
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ACP_OFF_SC1 4'h0
`define ACP_OFF_SC2 4'h1
`define ACP_OFF_RH 4'h2
`define ACP_OFF_RL 4'h3
`define ACP_OFF_CVH 4'h4
`define ACP_OFF_CVL 4'h5
`define ACP_OFF_CFG 4'h6
`define ACP_OFF_PC1 4'h7
`define ACP_OFF_PC2 4'h8

// ----------------------------------------------------------------
// Field positions and encodings
// ----------------------------------------------------------------
`define ACP_CFG_LP 7
`define ACP_CFG_DIV_HI 6
`define ACP_CFG_DIV_LO 5
`define ACP_CFG_LSMP 4
`define ACP_CFG_MODE_HI 3
`define ACP_CFG_MODE_LO 2
`define ACP_CFG_CLK_HI 1
`define ACP_CFG_CLK_LO 0
`define ACP_SC2_ACT 7
`define ACP_SC2_TRG 6
`define ACP_SC2_CFE 5
`define ACP_SC2_CGT 4
`define ACP_SC1_COMPLETION_FLAG 7
`define ACP_SC1_IEN 6
`define ACP_SC1_CONT 5
`define ACP_MODE_10 2'h2
`define ACP_CLK_ASYNC 2'h3
`define ACP_CH_OFF 5'h1F

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define ACP_RST_SC1 8'h1F
`define ACP_RST_ZERO 8'h00
`define ACP_CONV_CYC 8'h17

`endif

/* File: acp_pkg.sv */
// Types shared by the converter control files
package acp_pkg;
	typedef enum logic [1:0] {
		ACP_RUN = 2'b00,
		ACP_STOP3 = 2'b01,
		ACP_STOP12 = 2'b10
	} acp_pmode_e;

	typedef enum logic [0:0] {
		ACP_IDLE = 1'b0,
		ACP_CONV = 1'b1
	} acp_state_e;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} acp_bus_s;
endpackage

/* File: acp_pinmux.sv */
// Pin control register for analog input pins
`include "acp_params.svh"
module acp_pinmux #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clr,
	input wire logic we,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] ctl_q
);
	// Set bits hand the pin to the converter
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_q <= '0;
		end else if (clr) begin
			ctl_q <= '0;
		end else if (we) begin
			ctl_q <= wdata; // [R20]
		end
	end
endmodule

/* File: acp_ctrl_test.sv */
// Self-checking testbench for the converter control block
`include "acp_params.svh"
module acp_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk;
	logic rst_b;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic [1:0] pmode;
	logic hw_trig;
	logic [9:0] conv_data;
	logic irq;
	logic [4:0] channel;
	logic [7:0] gpio_dis_one;
	logic [7:0] gpio_dis_two;
	int n_fail;
	int samples_checked;

	acp_ctrl #(.CONV_CYC(23)) uut (
		.CLK(clk),
		.RST_B(rst_b),
		.ADDR(addr),
		.WDATA(wdata),
		.WR(wr),
		.RD(rd),
		.RDATA(rdata),
		.PMODE(pmode),
		.HW_TRIG(hw_trig),
		.CONV_DATA(conv_data),
		.IRQ(irq),
		.CHANNEL(channel),
		.GPIO_DIS_ONE(gpio_dis_one),
		.GPIO_DIS_TWO(gpio_dis_two)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic set_mode(input logic [1:0] m);
		@(posedge clk);
		pmode <= m;
	endtask

	// Bounded wait for the completion interrupt
	task automatic wait_irq(input int n);
		int i;
		i = 0;
		while (irq !== 1'b1 && i < n) begin
			@(posedge clk);
			#1;
			i++;
		end
		chk({7'h00, irq}, 8'h01);
	endtask

	task automatic chk_reset_state();
		rd_reg(`ACP_OFF_SC1, `ACP_RST_SC1);
		rd_reg(`ACP_OFF_SC2, 8'h00);
		rd_reg(`ACP_OFF_CFG, 8'h00);
		rd_reg(`ACP_OFF_RH, 8'h00);
		rd_reg(`ACP_OFF_RL, 8'h00);
		rd_reg(`ACP_OFF_CVL, 8'h00);
		rd_reg(`ACP_OFF_CVH, 8'h00);
		chk({3'h0, channel}, 8'h1F);
		chk(gpio_dis_one, 8'h00);
		chk(gpio_dis_two, 8'h00);
		chk({7'h00, irq}, 8'h00);
	endtask

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	initial begin
		#100000;
		n_fail++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		n_fail = 0;
		samples_checked = 0;
		rst_b = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		pmode = acp_pkg::ACP_RUN;
		hw_trig = 1'b0;
		conv_data = 10'h000;
		cyc(12);
		rst_b <= 1'b1;
		chk_reset_state();
		rd_reg(4'hF, 8'h00);
		// Field layout and reserved bits
		wr_reg(`ACP_OFF_CFG, 8'h98);
		rd_reg(`ACP_OFF_CFG, 8'h98);
		wr_reg(`ACP_OFF_SC2, 8'h7C);
		rd_reg(`ACP_OFF_SC2, 8'h70);
		wr_reg(`ACP_OFF_SC2, 8'h0C);
		rd_reg(`ACP_OFF_SC2, 8'h00);
		wr_reg(`ACP_OFF_CVL, 8'h5A);
		rd_reg(`ACP_OFF_CVL, 8'h5A);
		wr_reg(`ACP_OFF_CVL, 8'h00);
		wr_reg(`ACP_OFF_PC1, 8'h02);
		wr_reg(`ACP_OFF_PC2, 8'h04);
		cyc(1);
		chk(gpio_dis_one, 8'h02);
		chk(gpio_dis_two, 8'h04);
		rd_reg(`ACP_OFF_PC1, 8'h02);
		rd_reg(`ACP_OFF_PC2, 8'h04);
		// Single software-started conversion
		conv_data <= 10'h2A5;
		wr_reg(`ACP_OFF_SC1, 8'h41);
		rd_reg(`ACP_OFF_SC2, 8'h80);
		chk({3'h0, channel}, 8'h01);
		wait_irq(40);
		rd_reg(`ACP_OFF_SC1, 8'hC1);
		rd_reg(`ACP_OFF_RH, 8'h02);
		rd_reg(`ACP_OFF_RL, 8'hA5);
		cyc(30);
		rd_reg(`ACP_OFF_SC2, 8'h00);
		// Async clock: conversion runs through stop3
		wr_reg(`ACP_OFF_CFG, 8'h9B);
		conv_data <= 10'h3FF;
		wr_reg(`ACP_OFF_SC1, 8'h41);
		cyc(3);
		set_mode(acp_pkg::ACP_STOP3);
		wait_irq(40);
		rd_reg(`ACP_OFF_SC1, 8'hC1);
		rd_reg(`ACP_OFF_RH, 8'h03);
		rd_reg(`ACP_OFF_RL, 8'hFF);
		// Hardware trigger while stopped
		wr_reg(`ACP_OFF_SC2, 8'h40);
		conv_data <= 10'h155;
		@(posedge clk);
		hw_trig <= 1'b1;
		@(posedge clk);
		hw_trig <= 1'b0;
		wait_irq(40);
		rd_reg(`ACP_OFF_RH, 8'h01);
		rd_reg(`ACP_OFF_RL, 8'h55);
		set_mode(acp_pkg::ACP_RUN);
		// Result read in progress blocks the next result
		wr_reg(`ACP_OFF_SC2, 8'h00);
		conv_data <= 10'h111;
		wr_reg(`ACP_OFF_SC1, 8'h01);
		rd_reg(`ACP_OFF_RH, 8'h01);
		cyc(30);
		rd_reg(`ACP_OFF_SC1, 8'h01);
		rd_reg(`ACP_OFF_RL, 8'h55);
		cyc(30);
		rd_reg(`ACP_OFF_SC1, 8'h81);
		rd_reg(`ACP_OFF_RH, 8'h01);
		rd_reg(`ACP_OFF_RL, 8'h11);
		// Bus clock: stop3 entry aborts, stays idle afterwards
		wr_reg(`ACP_OFF_CFG, 8'h98);
		conv_data <= 10'h0CC;
		wr_reg(`ACP_OFF_SC1, 8'h01);
		cyc(5);
		set_mode(acp_pkg::ACP_STOP3);
		cyc(2);
		rd_reg(`ACP_OFF_SC2, 8'h00);
		set_mode(acp_pkg::ACP_RUN);
		cyc(40);
		rd_reg(`ACP_OFF_SC1, 8'h01);
		rd_reg(`ACP_OFF_RH, 8'h01);
		rd_reg(`ACP_OFF_RL, 8'h11);
		// Compare gates completion and stores the difference
		wr_reg(`ACP_OFF_CVH, 8'h01);
		rd_reg(`ACP_OFF_CVH, 8'h01);
		wr_reg(`ACP_OFF_SC2, 8'h30);
		conv_data <= 10'h155;
		wr_reg(`ACP_OFF_SC1, 8'h01);
		cyc(30);
		rd_reg(`ACP_OFF_SC1, 8'h81);
		rd_reg(`ACP_OFF_RH, 8'h00);
		rd_reg(`ACP_OFF_RL, 8'h55);
		conv_data <= 10'h0CC;
		wr_reg(`ACP_OFF_SC1, 8'h01);
		cyc(30);
		rd_reg(`ACP_OFF_SC2, 8'h30);
		rd_reg(`ACP_OFF_SC1, 8'h01);
		wr_reg(`ACP_OFF_SC2, 8'h00);
		wr_reg(`ACP_OFF_CVH, 8'h00);
		// Continuous conversions keep the converter active
		wr_reg(`ACP_OFF_SC1, 8'h21);
		cyc(60);
		rd_reg(`ACP_OFF_SC2, 8'h80);
		// Stop1/stop2 returns everything to reset values
		set_mode(acp_pkg::ACP_STOP12);
		cyc(3);
		set_mode(acp_pkg::ACP_RUN);
		chk_reset_state();
		cyc(40);
		rd_reg(`ACP_OFF_SC2, 8'h00);
		// Full reconfiguration before converting again
		wr_reg(`ACP_OFF_CFG, 8'h98);
		wr_reg(`ACP_OFF_SC2, 8'h00);
		wr_reg(`ACP_OFF_SC1, 8'h41);
		wait_irq(40);
		rd_reg(`ACP_OFF_RH, 8'h00);
		rd_reg(`ACP_OFF_RL, 8'hCC);
		complete_run();
	end
endmodule
